/* logic/clock_pulse_pkg.sv */
`default_nettype none
package clock_pulse_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [31:0] FREQ_CTRL_ADDR  = 32'hffffff80;
	localparam logic [31:0] WDOG_CTRL_ADDR  = 32'hffffff84;
	localparam logic [31:0] WDOG_COUNT_ADDR = 32'hffffff88;
	localparam logic [31:0] STATUS_ADDR     = 32'hffffff8c;
	localparam logic [15:0] FREQ_CTRL_RESET = 16'h0102;
	localparam logic [8:0]  WDOG_CTRL_RESET = 9'h000;
	localparam logic [7:0]  WDOG_COUNT_RESET = 8'h00;
	localparam logic [15:0] FREQ_CTRL_MASK  = 16'h073f;
	localparam int PDIV_LSB     = 0;
	localparam int CDIV_LSB     = 2;
	localparam int MULT_LSB     = 4;
	localparam int CKO_EN_BIT   = 8;
	localparam int PLL_STBY_BIT = 9;
	localparam int PLL1_ON_BIT  = 10;
	localparam int CKS_LSB      = 0;
	localparam int RST_TYPE_BIT = 5;
	localparam int WD_MODE_BIT  = 6;
	localparam int WD_RUN_BIT   = 7;
	localparam int WD_OVF_BIT   = 8;
	localparam int ST_SETTLE_BIT = 0;
	localparam int ST_SLEEP_BIT  = 1;
	localparam int ST_STBY_BIT   = 2;
	localparam int ST_BADWR_BIT  = 3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// clock modes and prescales
	// ----------------------------------------
	localparam logic [2:0] MODE_EXT_X4  = 3'h1;
	localparam logic [2:0] MODE_CRYSTAL_DRIVE_OUT_X4 = 3'h2;
	localparam logic [2:0] MODE_OPT_EXT = 3'h3;
	localparam logic [2:0] MODE_OPT_CRYSTAL_DRIVE_OUT = 3'h4;
	localparam logic [2:0] MODE_PIN_IN  = 3'h7;
	localparam int MODULE_COUNT = 3;
	localparam logic [11:0] WDOG_PRESCALE_MASK [8] = '{12'h000,
		12'h003, 12'h00f, 12'h01f, 12'h03f, 12'h0ff, 12'h3ff,
		12'hfff};
	typedef enum logic [1:0] {RUN, SLEEP, STANDBY, SETTLE} cpg_state_t;
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} axil_req_t;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_t;
endpackage
`default_nettype wire

/* logic/clock_pulse_unit.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module clock_pulse_unit #(
	parameter int BUS_PERIOD  = 24,
	parameter bit THIRD_RATIO = 1'b0
) (
	input  wire logic                       mclk_i,
	input  wire logic                       srst_i,
	input  wire clock_pulse_pkg::axil_req_t axil_i,
	output var  clock_pulse_pkg::axil_rsp_t axil_o,
	input  wire logic                       clock_mode_sel0_i,
	input  wire logic                       clock_mode_sel1_i,
	input  wire logic                       clock_mode_sel2_i,
	input  wire logic                       sleep_req_i,
	input  wire logic                       standby_req_i,
	input  wire logic [2:0]                 module_stop_i,
	input  wire logic                       bus_clock_pin_i,
	output logic                            bus_clock_pin_o,
	output logic                            bus_clock_pin_oe_o,
	output logic                            core_clk_en_o,
	output logic                            periph_clk_en_o,
	output logic [2:0]                      module_clk_en_o,
	output logic                            crystal_osc_en_o,
	output logic                            pll1_run_o,
	output logic                            pll2_x4_o,
	output logic                            wdog_reset_o,
	output logic                            wdog_poweron_o,
	output logic                            timer_irq_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	localparam logic [9:0] BUS_LAST = 10'(BUS_PERIOD - 1);
	localparam logic [9:0] BUS_HALF = 10'(BUS_PERIOD / 2);

	typedef struct packed {
		clock_pulse_pkg::cpg_state_t st;
		logic [2:0]  mode_s1, mode_s2, mode, pin_sync;
		logic [15:0] frq, act;
		logic [8:0]  wctl;
		logic [7:0]  wcnt;
		logic [11:0] pre;
		logic        bad_wr;
		logic [9:0]  bus_cnt, core_cnt, per_cnt;
		logic        bus_o;
		logic        core_en;
		logic        per_en;
		logic [2:0]  mod_en;
		logic        wrst;
		logic        tirq;
		logic        aw_held;
		logic [31:0] awaddr;
		logic        w_held;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} state_t;

	state_t state_reg;
	state_t state_next;

	logic        ext_mode, pll1_run, bus_edge, run, per_live;
	logic        wd_in, wd_on, wtick, ovf, aw_rdy, w_rdy, ar_rdy;
	logic        do_wr, change, rd_hit;
	logic [9:0]  core_per, per_per;
	logic [15:0] wr_frq;
	logic [31:0] rd_data;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// code 11 is the optional x3 or 1/3 setting
	function automatic logic [2:0] ratio(input logic [1:0] c);
		unique case (c)
			2'h0: ratio = 3'h1;
			2'h1: ratio = 3'h2;
			2'h2: ratio = 3'h4;
			2'h3: ratio = 3'h3;
		endcase
	endfunction
	function automatic logic pll_on(input logic [15:0] f,
		input logic [2:0] md);
		if (md == clock_pulse_pkg::MODE_OPT_EXT ||
			md == clock_pulse_pkg::MODE_OPT_CRYSTAL_DRIVE_OUT) begin
			pll_on = f[clock_pulse_pkg::PLL1_ON_BIT];
		end else begin
			pll_on = 1'b1;
		end
	endfunction
	// with the multiplier stopped, dividers see the bus clock
	function automatic logic [2:0] mult_eff(input logic [15:0] f,
		input logic [2:0] md);
		mult_eff = pll_on(f, md) ?
			ratio(f[clock_pulse_pkg::MULT_LSB +: 2]) : 3'h1;
	endfunction
	function automatic logic [9:0] period(input logic [1:0] d,
		input logic [2:0] m);
		period = 10'((BUS_PERIOD * int'(ratio(d))) / int'(m));
	endfunction
	function automatic logic ratio_ok(input logic [15:0] f,
		input logic [2:0] md);
		logic [2:0] m;
		logic       thirds;
		m = mult_eff(f, md);
		thirds = f[clock_pulse_pkg::MULT_LSB +: 2] == 2'h3 ||
			f[clock_pulse_pkg::CDIV_LSB +: 2] == 2'h3 ||
			f[clock_pulse_pkg::PDIV_LSB +: 2] == 2'h3;
		ratio_ok = (THIRD_RATIO || !thirds) &&
			ratio(f[clock_pulse_pkg::CDIV_LSB +: 2]) <= m &&
			ratio(f[clock_pulse_pkg::PDIV_LSB +: 2]) >= m;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] o,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		ext_mode = state_reg.mode == clock_pulse_pkg::MODE_PIN_IN;
		pll1_run = pll_on(state_reg.act, state_reg.mode);
		core_per = period(state_reg.act[clock_pulse_pkg::CDIV_LSB +: 2],
			mult_eff(state_reg.act, state_reg.mode));
		per_per = period(state_reg.act[clock_pulse_pkg::PDIV_LSB +: 2],
			mult_eff(state_reg.act, state_reg.mode));
		run = state_reg.st == clock_pulse_pkg::RUN;
		per_live = run || state_reg.st == clock_pulse_pkg::SLEEP;

		// bus clock: pin edge in input mode, own divider otherwise
		bus_edge = ext_mode ?
			(state_reg.pin_sync[1] && !state_reg.pin_sync[2]) :
			state_reg.bus_cnt == BUS_LAST;
		state_next.bus_cnt = bus_edge ? 10'h000 :
			state_reg.bus_cnt + 10'h001;
		state_next.bus_o = state_next.bus_cnt < BUS_HALF &&
			state_reg.frq[clock_pulse_pkg::CKO_EN_BIT];

		// core divider restarts on each bus rising edge; the peripheral
		// one runs free, else it could never be slower than the bus
		state_next.core_cnt = (bus_edge ||
			state_reg.core_cnt >= core_per - 10'h001) ? 10'h000 :
			state_reg.core_cnt + 10'h001;
		state_next.per_cnt = state_reg.per_cnt >= per_per - 10'h001 ?
			10'h000 : state_reg.per_cnt + 10'h001;

		// sleep stops the core only, standby and settling stop all
		state_next.core_en = state_reg.core_cnt == 10'h000 && run;
		state_next.per_en = state_reg.per_cnt == 10'h000 && per_live;
		state_next.mod_en = {3{state_next.per_en}} & ~module_stop_i;

		// watchdog counts oscillator cycles while settling
		wd_in = state_reg.st == clock_pulse_pkg::SETTLE ? 1'b1 :
			state_next.per_en;
		wd_on = state_reg.st == clock_pulse_pkg::SETTLE ||
			state_reg.wctl[clock_pulse_pkg::WD_RUN_BIT];
		wtick = wd_in && wd_on && (state_reg.pre &
			clock_pulse_pkg::WDOG_PRESCALE_MASK[
			state_reg.wctl[clock_pulse_pkg::CKS_LSB +: 3]]) ==
			clock_pulse_pkg::WDOG_PRESCALE_MASK[
			state_reg.wctl[clock_pulse_pkg::CKS_LSB +: 3]];
		ovf = wtick && state_reg.wcnt == 8'hff;
		if (wd_in && wd_on) begin
			state_next.pre = state_reg.pre + 12'h001;
		end
		if (wtick) begin
			state_next.wcnt = state_reg.wcnt + 8'h01;
		end
		state_next.wrst = 1'b0;
		state_next.tirq = 1'b0;
		if (ovf && state_reg.st != clock_pulse_pkg::SETTLE) begin
			if (state_reg.wctl[clock_pulse_pkg::WD_MODE_BIT]) begin
				state_next.wrst = 1'b1;
			end else begin
				state_next.tirq = 1'b1;
			end
		end

		// ----------------------------------------
		// register bus
		// ----------------------------------------
		aw_rdy = !state_reg.aw_held && !state_reg.bvalid;
		w_rdy = !state_reg.w_held && !state_reg.bvalid;
		ar_rdy = !state_reg.rvalid;
		if (axil_i.awvalid && aw_rdy) begin
			state_next.aw_held = 1'b1;
			state_next.awaddr = axil_i.awaddr;
		end
		if (axil_i.wvalid && w_rdy) begin
			state_next.w_held = 1'b1;
			state_next.wdata = axil_i.wdata;
			state_next.wstrb = axil_i.wstrb;
		end
		if (state_reg.bvalid && axil_i.bready) begin
			state_next.bvalid = 1'b0;
		end
		do_wr = state_reg.aw_held && state_reg.w_held;
		wr_frq = merge16(state_reg.frq, state_reg.wdata,
			state_reg.wstrb) & clock_pulse_pkg::FREQ_CTRL_MASK;
		change = 1'b0;
		if (do_wr) begin
			state_next.aw_held = 1'b0;
			state_next.w_held = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = clock_pulse_pkg::RESP_OKAY;
			unique case (state_reg.awaddr)
				clock_pulse_pkg::FREQ_CTRL_ADDR: begin
					// illegal ratios leave the register untouched
					if (ratio_ok(wr_frq, state_reg.mode)) begin
						state_next.frq = wr_frq;
						change = wr_frq[10:0] != state_reg.act[10:0];
					end else begin
						state_next.bad_wr = 1'b1;
					end
				end
				clock_pulse_pkg::WDOG_CTRL_ADDR: begin
					if (state_reg.wstrb[0]) begin
						state_next.wctl[7:0] = state_reg.wdata[7:0];
					end
					if (state_reg.wstrb[1] && !state_reg.wdata[8]) begin
						state_next.wctl[clock_pulse_pkg::WD_OVF_BIT] = 1'b0;
					end
				end
				clock_pulse_pkg::WDOG_COUNT_ADDR: begin
					if (state_reg.wstrb[0]) begin
						state_next.wcnt = state_reg.wdata[7:0];
					end
				end
				clock_pulse_pkg::STATUS_ADDR: begin
					if (state_reg.wstrb[0] && state_reg.wdata[3]) begin
						state_next.bad_wr = 1'b0;
					end
				end
				default: begin
					state_next.bresp = clock_pulse_pkg::RESP_SLVERR;
				end
			endcase
		end
		// a new overflow beats a same-cycle clear
		if (ovf && state_reg.st != clock_pulse_pkg::SETTLE) begin
			state_next.wctl[clock_pulse_pkg::WD_OVF_BIT] = 1'b1;
		end

		rd_hit = 1'b1;
		unique case (axil_i.araddr)
			clock_pulse_pkg::FREQ_CTRL_ADDR:
				rd_data = {16'h0000, state_reg.frq};
			clock_pulse_pkg::WDOG_CTRL_ADDR:
				rd_data = {23'h000000, state_reg.wctl};
			clock_pulse_pkg::WDOG_COUNT_ADDR:
				rd_data = {24'h000000, state_reg.wcnt};
			clock_pulse_pkg::STATUS_ADDR:
				rd_data = {28'h0000000, state_reg.bad_wr,
					state_reg.st == clock_pulse_pkg::STANDBY,
					state_reg.st == clock_pulse_pkg::SLEEP,
					state_reg.st == clock_pulse_pkg::SETTLE};
			default: begin
				rd_data = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
		if (state_reg.rvalid && axil_i.rready) begin
			state_next.rvalid = 1'b0;
		end
		if (axil_i.arvalid && ar_rdy) begin
			state_next.rvalid = 1'b1;
			state_next.rdata = rd_data;
			state_next.rresp = rd_hit ? clock_pulse_pkg::RESP_OKAY :
				clock_pulse_pkg::RESP_SLVERR;
		end

		// ----------------------------------------
		// power and settling sequence
		// ----------------------------------------
		unique case (state_reg.st)
			clock_pulse_pkg::RUN: begin
				if (standby_req_i) begin
					state_next.st = clock_pulse_pkg::STANDBY;
				end else if (sleep_req_i) begin
					state_next.st = clock_pulse_pkg::SLEEP;
				end else if (change) begin
					state_next.st = clock_pulse_pkg::SETTLE;
				end
			end
			clock_pulse_pkg::SLEEP: begin
				if (!sleep_req_i) begin
					state_next.st = clock_pulse_pkg::RUN;
				end
			end
			clock_pulse_pkg::STANDBY: begin
				if (!standby_req_i) begin
					state_next.st = clock_pulse_pkg::SETTLE;
				end
			end
			clock_pulse_pkg::SETTLE: begin
				if (ovf) begin
					// new ratios switch in while core and peripheral clocks are gated
					state_next.act = state_reg.frq;
					state_next.st = clock_pulse_pkg::RUN;
				end
			end
		endcase
		if (state_next.st == clock_pulse_pkg::SETTLE &&
			state_reg.st != clock_pulse_pkg::SETTLE) begin
			state_next.wcnt = 8'h00;
			state_next.pre = 12'h000;
		end

		// pin reset: registers back to defaults, mode pins latched
		if (srst_i) begin
			state_next = '0;
			state_next.mode = state_reg.mode_s2;
			state_next.frq = clock_pulse_pkg::FREQ_CTRL_RESET;
			state_next.act = clock_pulse_pkg::FREQ_CTRL_RESET;
			state_next.wctl = clock_pulse_pkg::WDOG_CTRL_RESET;
			state_next.wcnt = clock_pulse_pkg::WDOG_COUNT_RESET;
		end

		// synchronisers run in reset; first flop feeds only the second
		state_next.mode_s1 = {clock_mode_sel2_i, clock_mode_sel1_i,
			clock_mode_sel0_i};
		state_next.mode_s2 = state_reg.mode_s1;
		state_next.pin_sync = {state_reg.pin_sync[1:0], bus_clock_pin_i};
	end

	always_ff @(posedge mclk_i) begin
		state_reg <= state_next;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign axil_o.awready = aw_rdy && !srst_i;
	assign axil_o.wready = w_rdy && !srst_i;
	assign axil_o.bvalid = state_reg.bvalid;
	assign axil_o.bresp = state_reg.bresp;
	assign axil_o.arready = ar_rdy && !srst_i;
	assign axil_o.rvalid = state_reg.rvalid;
	assign axil_o.rdata = state_reg.rdata;
	assign axil_o.rresp = state_reg.rresp;

	assign bus_clock_pin_o = state_reg.bus_o;
	assign bus_clock_pin_oe_o = !ext_mode;
	assign core_clk_en_o = state_reg.core_en;
	assign periph_clk_en_o = state_reg.per_en;
	assign module_clk_en_o = state_reg.mod_en;
	assign crystal_osc_en_o = state_reg.mode ==
		clock_pulse_pkg::MODE_CRYSTAL_DRIVE_OUT_X4 || state_reg.mode ==
		clock_pulse_pkg::MODE_OPT_CRYSTAL_DRIVE_OUT;
	assign pll1_run_o = pll1_run;
	assign pll2_x4_o = state_reg.mode == clock_pulse_pkg::MODE_EXT_X4 ||
		state_reg.mode == clock_pulse_pkg::MODE_CRYSTAL_DRIVE_OUT_X4;
	assign wdog_reset_o = state_reg.wrst;
	assign wdog_poweron_o = !state_reg.wctl[clock_pulse_pkg::RST_TYPE_BIT];
	assign timer_irq_o = state_reg.tirq;
endmodule
`default_nettype wire

/* dv/clock_pulse_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module clock_pulse_checker #(
	parameter int BUS_PERIOD  = 24,
	parameter bit THIRD_RATIO = 1'b0
) (
	input wire logic                       mclk_i,
	input wire logic                       srst_i,
	input wire clock_pulse_pkg::axil_req_t axil_i,
	input wire clock_pulse_pkg::axil_rsp_t axil_o,
	input wire logic                       sleep_req_i,
	input wire logic                       standby_req_i,
	input wire logic [2:0]                 module_stop_i,
	input wire logic                       bus_clock_pin_oe_o,
	input wire logic                       core_clk_en_o,
	input wire logic                       periph_clk_en_o,
	input wire logic [2:0]                 module_clk_en_o,
	input wire logic                       crystal_osc_en_o,
	input wire logic                       pll1_run_o,
	input wire logic                       pll2_x4_o,
	input wire logic                       wdog_reset_o,
	input wire logic                       timer_irq_o
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (srst_i);
	// --------------------
	// peripheral pulse spacing
	// --------------------
	// first pulse after reset is not judged: no earlier pulse to measure from
	logic [15:0] pgap;
	logic        pseen;
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			pgap  <= 16'h0000;
			pseen <= 1'b0;
		end else if (periph_clk_en_o) begin
			pgap  <= 16'h0000;
			pseen <= 1'b1;
		end else if (pgap != 16'hffff) begin
			pgap <= pgap + 16'h0001;
		end
	end
	// --------------------
	// properties
	// --------------------
	pll_pair_a: assert property (pll2_x4_o |-> pll1_run_o)
		else $error("x4 input stage without first multiplier");
	crystal_drive_out_pin_a: assert property (
		crystal_osc_en_o |-> bus_clock_pin_oe_o)
		else $error("crystal mode without driven bus pin");
	sleep_gate_a: assert property (
		sleep_req_i [*4] |-> !core_clk_en_o)
		else $error("core pulse during sleep");
	stby_gate_a: assert property (
		standby_req_i [*4] |-> !periph_clk_en_o && module_clk_en_o == 3'h0)
		else $error("peripheral pulse during standby");
	mod_stop_a: assert property (
		(module_clk_en_o & module_stop_i & $past(module_stop_i) &
		$past(module_stop_i, 2)) == 3'h0)
		else $error("stopped module still clocked");
	periph_gap_a: assert property (
		periph_clk_en_o && pseen |-> pgap >= 16'(BUS_PERIOD - 1))
		else $error("peripheral clock faster than bus clock");
	settle_gate_a: assert property (
		$fell(standby_req_i) |=> (!periph_clk_en_o && !core_clk_en_o) [*8])
		else $error("clocks back before settling");
	wd_pulse_a: assert property (
		wdog_reset_o |-> !timer_irq_o ##1 !wdog_reset_o)
		else $error("watchdog reset not a lone pulse");
	irq_pulse_a: assert property (timer_irq_o |=> !timer_irq_o)
		else $error("timer interrupt longer than one cycle");
	rd_answer_a: assert property (
		axil_i.arvalid && axil_o.arready |=> axil_o.rvalid)
		else $error("read answer late");
	wr_answer_a: assert property (
		axil_i.awvalid && axil_o.awready && axil_i.wvalid && axil_o.wready
		|-> ##2 axil_o.bvalid)
		else $error("write answer late");
	cover property (timer_irq_o);
	cover property (wdog_reset_o);
	cover property (sleep_req_i && periph_clk_en_o);
	cover property ($fell(standby_req_i));
endmodule
bind clock_pulse_unit clock_pulse_checker #(
	.BUS_PERIOD (BUS_PERIOD),
	.THIRD_RATIO(THIRD_RATIO)
) i_chk (
	.mclk_i(mclk_i), .srst_i(srst_i), .axil_i(axil_i), .axil_o(axil_o),
	.sleep_req_i(sleep_req_i), .standby_req_i(standby_req_i),
	.module_stop_i(module_stop_i), .bus_clock_pin_oe_o(bus_clock_pin_oe_o),
	.core_clk_en_o(core_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
	.module_clk_en_o(module_clk_en_o), .crystal_osc_en_o(crystal_osc_en_o),
	.pll1_run_o(pll1_run_o), .pll2_x4_o(pll2_x4_o),
	.wdog_reset_o(wdog_reset_o), .timer_irq_o(timer_irq_o)
);
`default_nettype wire

/* dv/board_clock_source.sv */
`timescale 1ns/1ps
`default_nettype none
module board_clock_source #(
	parameter int HALF_NS = 60
) (
	input  wire logic run_i,
	output var  logic clk_o
);
	// stands still low while the device owns the pin
	initial begin
		clk_o = 1'b0;
		forever begin
			#(HALF_NS);
			clk_o = run_i ? ~clk_o : 1'b0;
		end
	end
endmodule
`default_nettype wire

/* dv/clock_pulse_generator_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module clock_pulse_generator_ctrl_test;
	localparam int          BP = 24;
	localparam logic [31:0] FQ = clock_pulse_pkg::FREQ_CTRL_ADDR;
	localparam logic [31:0] WC = clock_pulse_pkg::WDOG_CTRL_ADDR;
	localparam logic [31:0] WN = clock_pulse_pkg::WDOG_COUNT_ADDR;
	localparam logic [31:0] ST = clock_pulse_pkg::STATUS_ADDR;
	logic                       mclk      = 1'b0;
	logic                       srst      = 1'b1;
	clock_pulse_pkg::axil_req_t axil_req  = '0;
	clock_pulse_pkg::axil_rsp_t axil_rsp;
	logic [2:0]                 md        = 3'h0;
	logic                       sleep_req = 1'b0;
	logic                       stby_req  = 1'b0;
	logic [2:0]                 mstop     = 3'h0;
	logic [2:0]                 mod_en;
	logic [7:0]                 obs;
	logic                       pin_o, pin_oe, brd_clk, core_en, per_en;
	logic                       crystal_drive_out, pll1, x4, wrst, wpor, tirq;
	wire logic                  pin_w;
	int                         fail_count = 0;
	int                         cmp_count  = 0;
	always #2.5 mclk = ~mclk;
	assign pin_w = pin_oe ? pin_o : brd_clk;
	assign obs = {wrst, tirq, mod_en, per_en, core_en, pin_o};
	clock_pulse_unit #(.BUS_PERIOD(BP), .THIRD_RATIO(1'b0)) i_dut (
		.mclk_i(mclk), .srst_i(srst), .axil_i(axil_req), .axil_o(axil_rsp),
		.clock_mode_sel0_i(md[0]), .clock_mode_sel1_i(md[1]),
		.clock_mode_sel2_i(md[2]), .sleep_req_i(sleep_req),
		.standby_req_i(stby_req), .module_stop_i(mstop),
		.bus_clock_pin_i(pin_w), .bus_clock_pin_o(pin_o),
		.bus_clock_pin_oe_o(pin_oe), .core_clk_en_o(core_en),
		.periph_clk_en_o(per_en), .module_clk_en_o(mod_en),
		.crystal_osc_en_o(crystal_drive_out), .pll1_run_o(pll1), .pll2_x4_o(x4),
		.wdog_reset_o(wrst), .wdog_poweron_o(wpor), .timer_irq_o(tirq)
	);
	board_clock_source #(.HALF_NS(BP * 5 / 2)) i_brd (
		.run_i(!pin_oe),
		.clk_o(brd_clk)
	);
	// --------------------
	// tasks
	// --------------------
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// handshakes are judged at the negedge, released after the taking edge
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic aw, w, b;
		b = 1'b0;
		@(posedge mclk);
		axil_req.awaddr  <= a;
		axil_req.wdata   <= d;
		axil_req.wstrb   <= 4'hf;
		axil_req.awvalid <= 1'b1;
		axil_req.wvalid  <= 1'b1;
		axil_req.bready  <= 1'b1;
		while (!b) begin
			@(negedge mclk);
			aw = axil_req.awvalid & axil_rsp.awready;
			w  = axil_req.wvalid & axil_rsp.wready;
			b  = axil_req.bready & axil_rsp.bvalid;
			@(posedge mclk);
			if (aw) axil_req.awvalid <= 1'b0;
			if (w) axil_req.wvalid <= 1'b0;
			if (b) axil_req.bready <= 1'b0;
		end
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar, v;
		v = 1'b0;
		@(posedge mclk);
		axil_req.araddr  <= a;
		axil_req.arvalid <= 1'b1;
		axil_req.rready  <= 1'b1;
		while (!v) begin
			@(negedge mclk);
			ar = axil_req.arvalid & axil_rsp.arready;
			v  = axil_req.rready & axil_rsp.rvalid;
			d  = axil_rsp.rdata;
			r  = axil_rsp.rresp;
			@(posedge mclk);
			if (ar) axil_req.arvalid <= 1'b0;
			if (v) axil_req.rready <= 1'b0;
		end
	endtask
	task automatic rd_chk(input string nm, input logic [31:0] a,
		input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(nm, d, exp);
	endtask
	task automatic cnt(input int idx, input int cyc, output logic [31:0] n);
		n = 0;
		repeat (cyc) begin
			@(negedge mclk);
			if (obs[idx] === 1'b1) n++;
		end
		@(posedge mclk);
	endtask
	task automatic gap(input int idx, output logic [31:0] g);
		g = 0;
		do @(negedge mclk); while (obs[idx] !== 1'b1);
		do begin
			@(negedge mclk);
			g++;
		end while (obs[idx] !== 1'b1);
		@(posedge mclk);
	endtask
	task automatic do_reset(input logic [2:0] m);
		@(posedge mclk);
		srst <= 1'b1;
		md   <= m;
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// --------------------
	// tests
	// --------------------
	// about four times the expected run length
	initial begin
		#(30000 * 5);
		fail_count++;
		end_sim();
	end
	initial begin
		logic [31:0] n, d;
		logic [1:0]  r;
		logic [2:0]  m;
		int          ml[6] = '{0, 1, 2, 3, 4, 7};
		logic [31:0] fq[4] = '{32'h0112, 32'h0111, 32'h012a, 32'h0102};
		int          cg[4] = '{BP / 2, BP / 2, BP, BP};
		int          pg[4] = '{BP * 2, BP, BP, BP * 4};
		logic [31:0] bad[2] = '{32'h0108, 32'h0110};
		foreach (ml[i]) begin
			m = 3'(ml[i]);
			do_reset(m);
			@(negedge mclk);
			chk("crystal_drive_out", crystal_drive_out, m == 3'h2 || m == 3'h4);
			chk("x4", x4, m == 3'h1 || m == 3'h2);
			chk("pll1", pll1, m != 3'h3 && m != 3'h4);
			chk("pin_oe", pin_oe, m != 3'h7);
		end
		cnt(2, BP * 40, n);
		chk("pin fed periph", n > 8 && n < 12, 1);
		do_reset(3'h3);
		wr(FQ, 32'h0502);
		cnt(0, 400, n);
		chk("pll1 on", pll1, 1);
		$display("test modes done");
		do_reset(3'h0);
		rd_chk("freq reset", FQ, 32'h0102);
		rd_chk("wdog reset", WC, 32'h0);
		rd(32'hffffff90, d, r);
		chk("unmapped resp", r, clock_pulse_pkg::RESP_SLVERR);
		chk("unmapped data", d, 0);
		foreach (fq[i]) begin
			wr(FQ, fq[i]);
			cnt(1, 200, n);
			chk("settle gate", n, 0);
			cnt(1, 200, n);
			gap(1, n);
			chk("core gap", n, cg[i]);
			gap(2, n);
			chk("periph gap", n, pg[i]);
			rd_chk("freq readback", FQ, fq[i]);
		end
		foreach (bad[i]) begin
			wr(FQ, bad[i]);
			rd_chk("freq kept", FQ, 32'h0102);
			rd(ST, d, r);
			chk("bad flag", d[3], 1);
			wr(ST, 32'h8);
		end
		$display("test ratios done");
		wr(FQ, 32'h0002);
		cnt(1, 400, n);
		cnt(0, BP * 4, n);
		chk("pin held", n, 0);
		wr(FQ, 32'h0102);
		cnt(1, 400, n);
		cnt(0, BP * 4, n);
		chk("pin toggles", n, BP * 2);
		$display("test bus pin done");
		sleep_req <= 1'b1;
		mstop     <= 3'h5;
		cnt(1, 8, n);
		cnt(1, 300, n);
		chk("sleep core", n, 0);
		cnt(3, 300, n);
		chk("stopped module", n, 0);
		cnt(4, 300, n);
		chk("running module", n != 0, 1);
		sleep_req <= 1'b0;
		mstop     <= 3'h0;
		stby_req  <= 1'b1;
		cnt(2, 8, n);
		cnt(2, 300, n);
		chk("standby periph", n, 0);
		stby_req <= 1'b0;
		cnt(2, 200, n);
		chk("wake settle", n, 0);
		cnt(2, 300, n);
		chk("wake run", n != 0, 1);
		$display("test power down done");
		wr(WN, 32'hfe);
		wr(WC, 32'h80);
		cnt(6, 400, n);
		chk("interval irq", n, 1);
		wr(WC, 32'h0);
		wr(WN, 32'hfe);
		wr(WC, 32'hc0);
		cnt(7, 400, n);
		chk("wdog reset", n, 1);
		chk("poweron type", wpor, 1);
		rd_chk("freq after wdog", FQ, 32'h0102);
		wr(WC, 32'he0);
		cnt(0, 2, n);
		chk("manual type", wpor, 0);
		$display("test watchdog done");
		end_sim();
	end
endmodule
`default_nettype wire
